// ==== verilog/otpg_regs.svh ====
// constants of the one-time-programmable serial access path
`ifndef OTPG_REGS_SVH
`define OTPG_REGS_SVH
`define OTPG_DATA_W 10
`define OTPG_ADDR_W 13
`define OTPG_DEPTH 8192
`define OTPG_CMD_W 4
`define OTPG_CNT_W 5
`define OTPG_CMD_READ 4'h1
`define OTPG_CMD_PROG 4'h2
`define OTPG_CMD_VERIFY 4'h3
`define OTPG_ID_LO 13'h0090
`define OTPG_ID_HI 13'h0096
`define OTPG_BUF_DEPTH 2
`endif

// ==== verilog/otpg_pkg.sv ====
// types of the one-time-programmable serial access path
package otpg_pkg;
`include "otpg_regs.svh"

	typedef enum logic [2:0] {
		ST_OFF,
		ST_CMD,
		ST_ADDR,
		ST_DATA,
		ST_RD,
		ST_OUT
	} otpg_state_e;

	typedef enum logic [1:0] {
		OP_READ,
		OP_PROG,
		OP_VERIFY
	} otpg_op_e;

	typedef struct packed {
		logic sclk_m;
		logic sclk_s;
		logic sclk_d;
		logic sdi_m;
		logic sdi_s;
		logic ent_m;
		logic ent_s;
		logic ent_d;
		logic mode;
		otpg_state_e st;
		otpg_op_e op;
		logic [`OTPG_CNT_W-1:0] cnt;
		logic [`OTPG_CMD_W-1:0] cmd;
		logic [`OTPG_ADDR_W-1:0] addr;
		logic [`OTPG_DATA_W-1:0] data;
		logic rd_en;
		logic rd_sent;
		logic rd_vld;
		logic we;
		logic [`OTPG_BUF_DEPTH-1:0][`OTPG_DATA_W-1:0] buf_q;
		logic [1:0] buf_n;
		logic [`OTPG_DATA_W-1:0] shift;
		logic sdo;
		logic sdo_oe;
		logic cmd_err;
		logic id_hit;
	} otpg_state_s;
endpackage : otpg_pkg

// ==== verilog/otpg_mem.sv ====
// write-once word store with registered read data
`timescale 1ns/100ps
module otpg_mem #(
	parameter int DATA_W = 10,
	parameter int DEPTH = 8192,
	parameter int ADDR_W = 13
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_re,
	input wire logic i_we,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	output logic [DATA_W-1:0] o_rdata
);
	// =========================================================
	// elaboration check
	if (DEPTH > (1 << ADDR_W) || DATA_W < 1) begin : g_bad
		$error("otpg_mem: depth does not fit the address width");
	end

	// =========================================================
	// storage; parts leave the factory blank, so every cell starts at zero
	// and programming only ever ors ones into a known word
	logic [DATA_W-1:0] mem [DEPTH] = '{default: '0};

	// programming only ever sets bits, there is no erase path
	always_ff @(posedge i_clk) begin
		if (i_ce && i_we) begin
			mem[i_addr] <= mem[i_addr] | i_wdata;
		end
	end

	// read data held in a register
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= '0;
		end else if (i_ce && i_re) begin
			o_rdata <= mem[i_addr];
		end
	end

	// =========================================================
	// checks
	a_write_once_bits: assert property (@(posedge i_clk)
		disable iff (!i_rst_b)
		(i_ce && i_we) |=> ((mem[$past(i_addr)] & $past(mem[i_addr]))
			== $past(mem[i_addr])))
		else $error("programming cleared a stored bit");
endmodule : otpg_mem

// ==== verilog/otpg_top.sv ====
// serial programming access path to the one-time-programmable store
// Contract
// - programming mode moves commands, addresses, data serially on few pins
// - mode entered by a dedicated entry action after power-up
// - only read, program and verify commands are accepted
// - clock-synchronous transfers, least significant bit first both ways
// - store is write-once; no command or path erases words
// - words 0x090 to 0x096, ten bits each, hold the protection code
`timescale 1ns/100ps
`include "otpg_regs.svh"
module otpg_top
	import otpg_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_sclk,
	input wire logic i_sdi,
	input wire logic i_prog_entry,
	output logic o_sdo,
	output logic o_sdo_oe,
	output logic o_prog_mode,
	output logic o_cmd_err,
	output logic o_id_hit
);
	localparam int DW = `OTPG_DATA_W;
	localparam int AW = `OTPG_ADDR_W;
	localparam int CW = `OTPG_CMD_W;
	localparam logic [`OTPG_CNT_W-1:0] CMD_LAST = `OTPG_CNT_W'(CW - 1);
	localparam logic [`OTPG_CNT_W-1:0] ADDR_LAST = `OTPG_CNT_W'(AW - 1);
	localparam logic [`OTPG_CNT_W-1:0] DATA_LAST = `OTPG_CNT_W'(DW - 1);

	otpg_state_s r;
	otpg_state_s next_r;
	logic [DW-1:0] mem_rdata;
	logic rise;
	logic fall;
	logic [CW-1:0] cmd_in;
	logic [AW-1:0] addr_in;
	logic [DW-1:0] data_in;
	logic buf_ready;
	logic buf_pop;
	logic [DW-1:0] buf_din;
	logic [1:0] buf_left;

	// =========================================================
	// word store
	otpg_mem #(
		.DATA_W(DW),
		.DEPTH(`OTPG_DEPTH),
		.ADDR_W(AW)
	) u_mem (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_ce(i_ce),
		.i_re(r.rd_en),
		.i_we(r.we),
		.i_addr(r.addr),
		.i_wdata(r.data),
		.o_rdata(mem_rdata)
	);

	// =========================================================
	// edge finding on the synchronised link clock
	assign rise = r.sclk_s & ~r.sclk_d;
	assign fall = ~r.sclk_s & r.sclk_d;
	// lsb first: new bit enters at the top and walks down
	assign cmd_in = {r.sdi_s, r.cmd[CW-1:1]};
	assign addr_in = {r.sdi_s, r.addr[AW-1:1]};
	assign data_in = {r.sdi_s, r.data[DW-1:1]};
	// verify returns stored xor expected, zero means a good compare
	assign buf_din = (r.op == OP_VERIFY) ? (mem_rdata ^ r.data) : mem_rdata;
	// a read is only issued while the buffer has room, so none is lost
	assign buf_ready = (r.buf_n != 2'(`OTPG_BUF_DEPTH));
	assign buf_pop = (r.st == ST_RD) && (r.buf_n != 2'h0);
	assign buf_left = buf_pop ? (r.buf_n - 2'h1) : r.buf_n;

	// =========================================================
	// next state
	always_comb begin
		next_r = r;
		// first stage feeds only the second stage
		next_r.sclk_m = i_sclk;
		next_r.sclk_s = r.sclk_m;
		next_r.sclk_d = r.sclk_s;
		next_r.sdi_m = i_sdi;
		next_r.sdi_s = r.sdi_m;
		next_r.ent_m = i_prog_entry;
		next_r.ent_s = r.ent_m;
		next_r.ent_d = r.ent_s;
		next_r.rd_en = 1'b0;
		next_r.we = 1'b0;
		next_r.rd_vld = r.rd_en;

		// two-entry buffer between store and shifter
		if (buf_pop) begin
			next_r.buf_q[0] = r.buf_q[1];
		end
		if (r.rd_vld) begin
			next_r.buf_q[buf_left[0]] = buf_din;
		end
		next_r.buf_n = buf_left + {1'b0, r.rd_vld};

		unique case (r.st)
			ST_OFF: begin
				// a low-to-high entry opens the mode; reset clears the sync stages, so an entry already high when reset ends also opens it
				if (r.ent_s && !r.ent_d) begin
					next_r.mode = 1'b1;
					next_r.st = ST_CMD;
					next_r.cnt = '0;
				end
			end
			ST_CMD: begin
				if (rise) begin
					next_r.cmd = cmd_in;
					next_r.cnt = r.cnt + `OTPG_CNT_W'(1);
					if (r.cnt == CMD_LAST) begin
						next_r.cnt = '0;
						next_r.cmd_err = 1'b0;
						next_r.id_hit = 1'b0;
						next_r.st = ST_ADDR;
						// anything other than the three commands is dropped
						unique case (cmd_in)
							`OTPG_CMD_READ: next_r.op = OP_READ;
							`OTPG_CMD_PROG: next_r.op = OP_PROG;
							`OTPG_CMD_VERIFY: next_r.op = OP_VERIFY;
							default: begin
								next_r.cmd_err = 1'b1;
								next_r.st = ST_CMD;
							end
						endcase
					end
				end
			end
			ST_ADDR: begin
				if (rise) begin
					next_r.addr = addr_in;
					next_r.cnt = r.cnt + `OTPG_CNT_W'(1);
					if (r.cnt == ADDR_LAST) begin
						next_r.cnt = '0;
						next_r.rd_sent = 1'b0;
						next_r.id_hit = (addr_in >= `OTPG_ID_LO) &&
							(addr_in <= `OTPG_ID_HI);
						next_r.st = (r.op == OP_READ) ? ST_RD : ST_DATA;
					end
				end
			end
			ST_DATA: begin
				if (rise) begin
					next_r.data = data_in;
					next_r.cnt = r.cnt + `OTPG_CNT_W'(1);
					if (r.cnt == DATA_LAST) begin
						next_r.cnt = '0;
						next_r.rd_sent = 1'b0;
						if (r.op == OP_PROG) begin
							next_r.we = 1'b1;
							next_r.st = ST_CMD;
						end else begin
							next_r.st = ST_RD;
						end
					end
				end
			end
			ST_RD: begin
				if (!r.rd_sent && buf_ready) begin
					next_r.rd_en = 1'b1;
					next_r.rd_sent = 1'b1;
				end
				if (buf_pop) begin
					// bit 0 goes out first, before the first rising edge
					next_r.shift = r.buf_q[0];
					next_r.sdo = r.buf_q[0][0];
					next_r.sdo_oe = 1'b1;
					next_r.st = ST_OUT;
				end
			end
			ST_OUT: begin
				if (fall && r.cnt != '0) begin
					next_r.shift = r.shift >> 1;
					next_r.sdo = r.shift[1];
				end
				if (rise) begin
					next_r.cnt = r.cnt + `OTPG_CNT_W'(1);
					if (r.cnt == DATA_LAST) begin
						next_r.cnt = '0;
						next_r.sdo = 1'b0;
						next_r.sdo_oe = 1'b0;
						next_r.st = ST_CMD;
					end
				end
			end
		endcase

		// dropping the entry level leaves the mode at once
		if (r.mode && !r.ent_s) begin
			next_r.mode = 1'b0;
			next_r.st = ST_OFF;
			next_r.cnt = '0;
			next_r.sdo = 1'b0;
			next_r.sdo_oe = 1'b0;
		end
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= '0;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	// =========================================================
	// outputs straight from the state register
	assign o_sdo = r.sdo;
	assign o_sdo_oe = r.sdo_oe;
	assign o_prog_mode = r.mode;
	assign o_cmd_err = r.cmd_err;
	assign o_id_hit = r.id_hit;

	// =========================================================
	// checks
	a_pin_idle_off: assert property (@(posedge i_clk)
		disable iff (!i_rst_b)
		!o_prog_mode |-> !o_sdo_oe)
		else $error("serial data driven outside programming mode");

	a_mode_entry_edge: assert property (@(posedge i_clk)
		disable iff (!i_rst_b)
		$rose(o_prog_mode) |-> ($past(r.ent_s) && !$past(r.ent_d)))
		else $error("programming mode opened without an entry edge");

	a_only_three_ops: assert property (@(posedge i_clk)
		disable iff (!i_rst_b)
		(i_ce && r.st == ST_CMD && rise && r.cnt == CMD_LAST &&
		!(cmd_in inside {`OTPG_CMD_READ, `OTPG_CMD_PROG,
		`OTPG_CMD_VERIFY}) && r.ent_s)
		|=> (r.st == ST_CMD && o_cmd_err))
		else $error("unknown command was not dropped");

	a_lsb_first_out: assert property (@(posedge i_clk)
		disable iff (!i_rst_b)
		(i_ce && r.st == ST_RD && buf_pop && r.ent_s)
		|=> (o_sdo_oe && o_sdo == $past(r.buf_q[0][0])))
		else $error("first bit out is not the least significant");

	a_no_stray_write: assert property (@(posedge i_clk)
		disable iff (!i_rst_b)
		r.we |-> ($past(r.st) == ST_DATA && r.op == OP_PROG))
		else $error("store written outside a program command");

	a_id_range_flag: assert property (@(posedge i_clk)
		disable iff (!i_rst_b)
		(o_id_hit && r.st != ST_ADDR) |->
		(r.addr >= `OTPG_ID_LO && r.addr <= `OTPG_ID_HI))
		else $error("protection word flag outside the reserved range");

	c_read_done: cover property (@(posedge i_clk) disable iff (!i_rst_b)
		(r.st == ST_OUT && r.op == OP_READ) ##1 (r.st == ST_CMD));
	c_program: cover property (@(posedge i_clk) disable iff (!i_rst_b)
		r.we);
	c_verify_id: cover property (@(posedge i_clk) disable iff (!i_rst_b)
		(r.op == OP_VERIFY && o_id_hit && o_sdo_oe));
endmodule : otpg_top

// ==== dv/otpg_prog_model.sv ====
// serial programmer model driving the link of the access path
`timescale 1ns/100ps
module otpg_prog_model (
	input wire logic i_clk,
	input wire logic i_sdo,
	input wire logic i_sdo_oe,
	output logic o_sclk,
	output logic o_sdi
);
	// link clock stands low between frames
	initial begin
		o_sclk = 1'b0;
		o_sdi = 1'b0;
	end

	// ==========================================================
	// bit and frame transfers
	// data set while the clock is low, taken by the device at the rise
	task automatic put_bit(input logic b);
		@(posedge i_clk) o_sdi <= b;
		repeat (8) @(posedge i_clk);
		o_sclk <= 1'b1;
		repeat (8) @(posedge i_clk);
		o_sclk <= 1'b0;
	endtask : put_bit

	// one frame; half sets the output clock, so slow hosts can stall
	task automatic frame(input logic [3:0] c, input logic [12:0] a,
		input logic [9:0] d, input int half, output logic [9:0] rd,
		output bit got);
		int i;
		rd = 10'h000;
		got = 1'b0;
		for (i = 0; i < 4; i++) put_bit(c[i]);
		if (c == 4'h1 || c == 4'h2 || c == 4'h3) begin
			for (i = 0; i < 13; i++) put_bit(a[i]);
			if (c != 4'h1) begin
				for (i = 0; i < 10; i++) put_bit(d[i]);
			end
		end
		// released data line must not hold a stale bit
		@(posedge i_clk) o_sdi <= ~o_sdi;
		if (c == 4'h1 || c == 4'h3) begin
			// bounded wait for the device to take the pin
			for (i = 0; i < 64 && !got; i++) begin
				@(negedge i_clk) got = i_sdo_oe;
			end
			repeat (16) @(posedge i_clk);
			for (i = 0; i < 10; i++) begin
				// a released line shows the inverse, so a dropped enable shows
				@(negedge i_clk) rd[i] = i_sdo_oe ? i_sdo : ~i_sdo;
				@(posedge i_clk) o_sclk <= 1'b1;
				o_sdi <= ~o_sdi;
				repeat (half) @(posedge i_clk);
				o_sclk <= 1'b0;
				repeat (half) @(posedge i_clk);
			end
		end
		repeat (8) @(posedge i_clk);
	endtask : frame
endmodule : otpg_prog_model

// ==== dv/test_otpg_top.sv ====
// self-checking bench for the serial programming access path
`timescale 1ns/100ps
module test_otpg_top;
`include "otpg_regs.svh"
	logic i_clk, i_rst_b, i_ce, i_sclk, i_sdi, i_prog_entry;
	logic o_sdo, o_sdo_oe, o_prog_mode, o_cmd_err, o_id_hit;
	int mismatches = 0;
	int samples_checked = 0;
	logic [9:0] rd;
	bit got;
	int k;

	otpg_top u_otpg_top (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_sclk(i_sclk), .i_sdi(i_sdi), .i_prog_entry(i_prog_entry),
		.o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_prog_mode(o_prog_mode),
		.o_cmd_err(o_cmd_err), .o_id_hit(o_id_hit));
	otpg_prog_model u_otpg_prog_model (.i_clk(i_clk), .i_sdo(o_sdo),
		.i_sdo_oe(o_sdo_oe), .o_sclk(i_sclk), .o_sdi(i_sdi));

	// ==========================================================
	// clock, compare and closing
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	task automatic run(input logic [3:0] c, input logic [12:0] a,
		input logic [9:0] d, input int half);
		u_otpg_prog_model.frame(c, a, d, half, rd, got);
	endtask : run

	// ==========================================================
	// scenarios
	// strap low through reset, then a rising entry edge
	task automatic t_entry();
		repeat (20) @(posedge i_clk);
		check({9'h0, o_prog_mode}, 10'h000);
		i_prog_entry <= 1'b1;
		repeat (12) @(posedge i_clk);
		check({9'h0, o_prog_mode}, 10'h001);
	endtask : t_entry
	// program sets bits only; a second program never clears any
	task automatic t_prog_read();
		run(`OTPG_CMD_PROG, 13'h1234, 10'h2A5, 8);
		run(`OTPG_CMD_READ, 13'h1234, 10'h000, 8);
		check(rd, 10'h2A5);
		check({9'h0, got}, 10'h001);
		check({9'h0, o_id_hit}, 10'h000);
		run(`OTPG_CMD_PROG, 13'h1234, 10'h05A, 8);
		run(`OTPG_CMD_READ, 13'h1234, 10'h000, 8);
		check(rd, 10'h2FF);
	endtask : t_prog_read
	// verify answers stored xor supplied
	task automatic t_verify();
		run(`OTPG_CMD_VERIFY, 13'h1234, 10'h2FF, 8);
		check(rd, 10'h000);
		run(`OTPG_CMD_VERIFY, 13'h1234, 10'h0F0, 8);
		check(rd, 10'h20F);
	endtask : t_verify
	// every unknown code is flagged; a valid one clears the flag
	task automatic t_bad_cmd();
		for (k = 0; k < 16; k++) begin
			if (k > 3 || k == 0) begin
				run(k[3:0], 13'h0000, 10'h000, 8);
				repeat (4) @(posedge i_clk);
				check({9'h0, o_cmd_err}, 10'h001);
			end
		end
		run(`OTPG_CMD_READ, 13'h1234, 10'h000, 8);
		check({9'h0, o_cmd_err}, 10'h000);
		check(rd, 10'h2FF);
	endtask : t_bad_cmd
	// protection words, boundaries, and the host-side code compare
	task automatic t_id();
		bit ok;
		ok = 1'b1;
		// a blank part reads all zero in the first reserved word
		run(`OTPG_CMD_READ, `OTPG_ID_LO, 10'h000, 8);
		check(rd, 10'h000);
		check({9'h0, o_id_hit}, 10'h001);
		for (k = 13'h0090; k <= 13'h0096; k++) begin
			run(`OTPG_CMD_PROG, k[12:0], 10'h16B, 8);
		end
		for (k = 13'h008F; k <= 13'h0097; k++) begin
			run(`OTPG_CMD_READ, k[12:0], 10'h000, 8);
			check({9'h0, o_id_hit}, {9'h0, k >= 8'h90 && k <= 8'h96});
			if (k >= 8'h90 && k <= 8'h96) begin
				check(rd, 10'h16B);
				ok = ok && (rd === 10'h16B);
			end else begin
				check(rd, 10'h000);
			end
		end
		// further work only after the codes agree
		if (ok) begin
			run(`OTPG_CMD_VERIFY, `OTPG_ID_LO, 10'h16B, 8);
			check(rd, 10'h000);
		end
	endtask : t_id
	// a frozen enable hides an entry drop; a live drop leaves the mode
	task automatic t_freeze_exit();
		i_ce <= 1'b0;
		i_prog_entry <= 1'b0;
		repeat (10) @(posedge i_clk);
		check({9'h0, o_prog_mode}, 10'h001);
		i_prog_entry <= 1'b1;
		repeat (4) @(posedge i_clk);
		i_ce <= 1'b1;
		repeat (10) @(posedge i_clk);
		check({9'h0, o_prog_mode}, 10'h001);
		i_prog_entry <= 1'b0;
		repeat (10) @(posedge i_clk);
		check({9'h0, o_prog_mode}, 10'h000);
		check({9'h0, o_sdo_oe}, 10'h000);
		i_prog_entry <= 1'b1;
		repeat (10) @(posedge i_clk);
		check({9'h0, o_prog_mode}, 10'h001);
		run(`OTPG_CMD_READ, 13'h1234, 10'h000, 8);
		check(rd, 10'h2FF);
	endtask : t_freeze_exit

	// ==========================================================
	// main sequence and watchdog
	initial begin
		i_rst_b = 1'b0;
		i_prog_entry = 1'b0;
		i_ce = 1'b1;
		repeat (6) @(posedge i_clk);
		i_rst_b <= 1'b1;
		t_entry();
		t_prog_read();
		t_verify();
		t_bad_cmd();
		t_id();
		t_freeze_exit();
		complete_run();
	end
	// whole run is about 15000 cycles; cut a hang at 50000
	initial begin
		#200000;
		mismatches++;
		complete_run();
	end
endmodule : test_otpg_top
